//--- rtl/dcc_pkg.sv
package dcc_pkg;
	// Register indices on the plain register port
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_INT_CTRL = 4'h0;
	localparam logic [3:0] OFF_FLAGS2 = 4'h1;
	localparam logic [3:0] OFF_ENABLES2 = 4'h2;
	localparam logic [3:0] OFF_PRIO2 = 4'h3;
	localparam logic [3:0] OFF_CMP_CTRL = 4'h4;
	localparam logic [3:0] OFF_LADDER = 4'h5;
	localparam logic [3:0] OFF_PORT_F_PINS_PINS = 4'h6;
	localparam logic [3:0] OFF_PORT_F_PINS_LAT = 4'h7;
	localparam logic [3:0] OFF_PORT_F_PINS_DIR = 4'h8;
	localparam logic [3:0] OFF_CONV_CTRL1 = 4'h9;

	// Field positions
	localparam int GIE_BIT = 7;
	localparam int PERIPHERAL_INT_ENABLE_BIT = 6;
	localparam int CHG_BIT = 6;
	localparam int RES2_BIT = 7;
	localparam int RES1_BIT = 6;
	localparam int INV2_BIT = 5;
	localparam int INV1_BIT = 4;
	localparam int ISW_BIT = 3;
	localparam int MODE_MSB = 2;
	localparam int PCFG_MSB = 3;
	localparam int PIN_C1 = 1;
	localparam int PIN_C2 = 2;

	// Writable masks and the analog pin set; other bits read as zero, except the control register result bits, which read the results
	localparam logic [7:0] CMP_WR_MASK = 8'h3F;
	localparam logic [7:0] FLAGS2_MASK = 8'hCE;
	localparam logic [7:0] PORT_F_PINS_MASK = 8'hFE;
	localparam logic [7:0] ANALOG_PINS = 8'h78;
	localparam logic [7:0] CONV1_MASK = 8'h0F;

	// Reset values and the all-digital configuration code
	localparam logic [7:0] CMP_RST = 8'h07;
	localparam logic [7:0] DIR_RST = 8'hFE;
	localparam logic [7:0] ZERO_RST = 8'h00;
	localparam logic [3:0] PCFG_ALL_DIGITAL = 4'hF;

	// Comparator modes
	localparam logic [2:0] MODE_INT_REF = 3'h6;
	localparam logic [2:0] MODE_OFF = 3'h7;
	localparam logic [2:0] MODE_PIN_OUT = 3'h3;
endpackage : dcc_pkg

//--- rtl/dcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_sync
	import dcc_pkg::*;
#(
	parameter int W = 2
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_r;

	// First stage is read by the second stage only
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			meta_r <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule : dcc_sync
`default_nettype wire

//--- rtl/dcc_top.sv
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dcc_top
	import dcc_pkg::*;
#(
	parameter logic [2:0] PIN_OUT_MODE = MODE_PIN_OUT
)(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_B_I,
	// Register port
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// Analog comparator cores
	input wire logic CMP1_RAW_I,
	input wire logic CMP2_RAW_I,
	output logic [2:0] CMP_MODE_O,
	output logic CMP_ON_O,
	output logic CMP_ISW_O,
	output logic CMP_POS_INTREF_O,
	output logic [7:0] LADDER_CTRL_O,
	// Port F pins
	input wire logic [7:0] PORT_F_PINS_IN_I,
	output logic [7:0] PORT_F_PINS_OUT_O,
	output logic [7:0] PORT_F_PINS_OE_O,
	output logic [7:0] PORT_F_PINS_ANALOG_O,
	// Power and interrupt
	input wire logic SLEEP_I,
	output logic CMP_IRQ_O,
	output logic CMP_IRQ_HIGH_O,
	output logic WAKE_O
);
	logic [7:0] intctl_r;
	logic [7:0] flags2_r;
	logic [7:0] en2_r;
	logic [7:0] prio2_r;
	logic [7:0] cmp_r;
	logic [7:0] ladder_r;
	logic [7:0] lat_r;
	logic [7:0] dir_r;
	logic [3:0] pcfg_r;
	logic [1:0] latch_r;
	logic [7:0] pin_out_r;
	logic [7:0] rdata_nxt;
	logic [1:0] raw;
	logic [1:0] raw_sync;
	logic [1:0] res;
	logic [1:0] inv;
	logic [2:0] mode;
	logic cmp_on;
	logic pin_mode;
	logic cmp_acc;
	logic mismatch;
	logic chg_set;
	logic chg_nxt;
	logic irq_nxt;

	function automatic logic wr_hit(input logic [3:0] off);
		wr_hit = WR_I && (ADDR_I == off);
	endfunction : wr_hit

	function automatic logic [7:0] analog_mask(input logic [3:0] pcfg);
		analog_mask = (pcfg == PCFG_ALL_DIGITAL) ? ZERO_RST : ANALOG_PINS;
	endfunction : analog_mask

	assign mode = cmp_r[MODE_MSB:0];
	assign inv = {cmp_r[INV2_BIT], cmp_r[INV1_BIT]};
	// Comparators off report a low level
	assign cmp_on = (mode != MODE_OFF);
	assign pin_mode = (mode == PIN_OUT_MODE);
	// High means positive input above negative input
	assign raw = {CMP2_RAW_I, CMP1_RAW_I} & {2{cmp_on}};

	// Sync first; compare of async levels could set a metastable flag
	dcc_sync #(
		.W(2)
	) u_sync (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.async_i(raw),
		.sync_o(raw_sync)
	);

	assign res = raw_sync ^ inv;
	assign cmp_acc = (WR_I || RD_I) && (ADDR_I == OFF_CMP_CTRL);
	assign mismatch = (res != latch_r);

	// Set term covers real changes and a software write of one
	// Process, not assign: the helper reads the strobe outside its arguments
	always_comb
	begin
		chg_set = mismatch
			|| (wr_hit(OFF_FLAGS2) && WDATA_I[CHG_BIT]);
	end

	// Set wins over a same-cycle clear; not cleared by hardware
	always_comb
	begin
		chg_nxt = flags2_r[CHG_BIT];
		if (wr_hit(OFF_FLAGS2))
		begin
			chg_nxt = WDATA_I[CHG_BIT];
		end
		if (chg_set)
		begin
			chg_nxt = 1'b1;
		end
	end

	// Access to control register reloads the mismatch latch
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			latch_r <= '0;
		end
		else if (cmp_acc)
		begin
			latch_r <= res;
		end
	end

	// Compare uses the old latch, so a change at an access is never lost
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			flags2_r <= ZERO_RST;
		end
		else
		begin
			if (wr_hit(OFF_FLAGS2))
			begin
				flags2_r <= WDATA_I & FLAGS2_MASK;
			end
			flags2_r[CHG_BIT] <= chg_nxt;
		end
	end

	// Control register: result bits are never stored
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			cmp_r <= CMP_RST;
		end
		else if (wr_hit(OFF_CMP_CTRL))
		begin
			cmp_r <= WDATA_I & CMP_WR_MASK;
		end
	end

	// Sleep touches no register; only reset or writes change them
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			intctl_r <= ZERO_RST;
			en2_r <= ZERO_RST;
			prio2_r <= ZERO_RST;
			ladder_r <= ZERO_RST;
		end
		else
		begin
			if (wr_hit(OFF_INT_CTRL))
			begin
				intctl_r <= WDATA_I;
			end
			if (wr_hit(OFF_ENABLES2))
			begin
				en2_r <= WDATA_I & FLAGS2_MASK;
			end
			if (wr_hit(OFF_PRIO2))
			begin
				prio2_r <= WDATA_I & FLAGS2_MASK;
			end
			if (wr_hit(OFF_LADDER))
			begin
				ladder_r <= WDATA_I;
			end
		end
	end

	// Port F latch, direction and analog configuration
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			lat_r <= ZERO_RST;
			dir_r <= DIR_RST;
			pcfg_r <= '0;
		end
		else
		begin
			if (wr_hit(OFF_PORT_F_PINS_LAT) || wr_hit(OFF_PORT_F_PINS_PINS))
			begin
				lat_r <= WDATA_I & PORT_F_PINS_MASK;
			end
			if (wr_hit(OFF_PORT_F_PINS_DIR))
			begin
				dir_r <= WDATA_I & PORT_F_PINS_MASK;
			end
			if (wr_hit(OFF_CONV_CTRL1))
			begin
				pcfg_r <= WDATA_I[PCFG_MSB:0];
			end
		end
	end

	// Read mux
	always_comb
	begin
		rdata_nxt = ZERO_RST;
		case (ADDR_I)
			OFF_INT_CTRL: rdata_nxt = intctl_r;
			OFF_FLAGS2: rdata_nxt = flags2_r;
			OFF_ENABLES2: rdata_nxt = en2_r;
			OFF_PRIO2: rdata_nxt = prio2_r;
			OFF_CMP_CTRL:
			begin
				rdata_nxt = cmp_r;
				rdata_nxt[RES2_BIT] = res[1];
				rdata_nxt[RES1_BIT] = res[0];
			end
			OFF_LADDER: rdata_nxt = ladder_r;
			OFF_PORT_F_PINS_PINS:
				rdata_nxt = PORT_F_PINS_IN_I & PORT_F_PINS_MASK & ~analog_mask(pcfg_r);
			OFF_PORT_F_PINS_LAT: rdata_nxt = lat_r;
			OFF_PORT_F_PINS_DIR: rdata_nxt = dir_r;
			OFF_CONV_CTRL1: rdata_nxt = {4'h0, pcfg_r};
			default: rdata_nxt = ZERO_RST;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			RDATA_O <= ZERO_RST;
		end
		else
		begin
			RDATA_O <= RD_I ? rdata_nxt : ZERO_RST;
		end
	end

	// Comparator and port F configuration outputs
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			CMP_MODE_O <= MODE_OFF;
			CMP_ON_O <= 1'b0;
			CMP_ISW_O <= 1'b0;
			CMP_POS_INTREF_O <= 1'b0;
			LADDER_CTRL_O <= ZERO_RST;
			PORT_F_PINS_OE_O <= ZERO_RST;
			PORT_F_PINS_ANALOG_O <= ANALOG_PINS;
			pin_out_r <= ZERO_RST;
		end
		else
		begin
			CMP_MODE_O <= mode;
			CMP_ON_O <= cmp_on;
			CMP_ISW_O <= cmp_r[ISW_BIT];
			// Internal reference only reachable in the four-input mode
			CMP_POS_INTREF_O <= (mode == MODE_INT_REF);
			LADDER_CTRL_O <= ladder_r;
			PORT_F_PINS_OE_O <= ~dir_r & PORT_F_PINS_MASK;
			PORT_F_PINS_ANALOG_O <= analog_mask(pcfg_r);
			pin_out_r <= lat_r;
		end
	end

	// Pin path bypasses the synchronizer on purpose; may glitch
	always_comb
	begin
		PORT_F_PINS_OUT_O = pin_out_r;
		if (pin_mode)
		begin
			PORT_F_PINS_OUT_O[PIN_C1] = raw[0] ^ inv[0];
			PORT_F_PINS_OUT_O[PIN_C2] = raw[1] ^ inv[1];
		end
	end

	// Interrupt request and wake; comparators run on in sleep
	assign irq_nxt = flags2_r[CHG_BIT] && en2_r[CHG_BIT]
		&& intctl_r[PERIPHERAL_INT_ENABLE_BIT] && intctl_r[GIE_BIT];

	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			CMP_IRQ_O <= 1'b0;
			CMP_IRQ_HIGH_O <= 1'b0;
		end
		else
		begin
			CMP_IRQ_O <= irq_nxt;
			CMP_IRQ_HIGH_O <= irq_nxt && prio2_r[CHG_BIT];
		end
	end

	// Wake needs only the local enable, not the global ones
	always_ff @(posedge CLK_I)
	begin
		if (!RST_B_I)
		begin
			WAKE_O <= 1'b0;
		end
		else
		begin
			WAKE_O <= SLEEP_I && flags2_r[CHG_BIT] && en2_r[CHG_BIT];
		end
	end
endmodule : dcc_top
`default_nettype wire

//--- bench/dcc_cores.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_cores (
	// Control
	input wire logic on_i,
	input wire logic intref_i,
	input wire logic [7:0] ref_i,
	// Levels as codes
	input wire logic [7:0] vp1_i,
	input wire logic [7:0] vn1_i,
	input wire logic [7:0] vp2_i,
	input wire logic [7:0] vn2_i,
	// Raw results
	output logic raw1_o,
	output logic raw2_o
);
	logic [7:0] p1;
	logic [7:0] p2;
	// Ladder code feeds both positive inputs
	assign p1 = intref_i ? {4'h0, ref_i[3:0]} : vp1_i;
	assign p2 = intref_i ? {4'h0, ref_i[3:0]} : vp2_i;
	// Off cores idle low
	assign raw1_o = on_i && (p1 > vn1_i);
	assign raw2_o = on_i && (p2 > vn2_i);
endmodule : dcc_cores
`default_nettype wire

//--- bench/dcc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor
	import dcc_pkg::*;
(
	// Bus
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic [ADDR_W-1:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	// Outputs
	input wire logic [2:0] CMP_MODE_O,
	input wire logic CMP_ON_O,
	input wire logic CMP_POS_INTREF_O,
	input wire logic [7:0] PORT_F_PINS_OE_O,
	input wire logic [7:0] PORT_F_PINS_ANALOG_O,
	input wire logic SLEEP_I,
	input wire logic CMP_IRQ_O,
	input wire logic WAKE_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	AST_ON: assert property (CMP_ON_O == (CMP_MODE_O != MODE_OFF))
		else $error("on flag wrong");
	AST_INTREF: assert property (CMP_POS_INTREF_O |-> CMP_MODE_O == MODE_INT_REF)
		else $error("intref outside mode");
	AST_RD_MODE: assert property (RD_I && ADDR_I == OFF_CMP_CTRL
		|=> RDATA_O[2:0] == CMP_MODE_O) else $error("mode readback");
	AST_RD_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("stray read data");
	AST_IRQ: assert property (WR_I && ADDR_I == OFF_INT_CTRL && !(&WDATA_I[7:6])
		|=> ##1 !CMP_IRQ_O) else $error("irq while disabled");
	AST_WAKE: assert property (WAKE_O |-> $past(SLEEP_I))
		else $error("wake without sleep");
	AST_OE: assert property (WR_I && ADDR_I == OFF_PORT_F_PINS_DIR
		|=> ##1 (PORT_F_PINS_OE_O | 8'h01) == (~$past(WDATA_I, 2) | 8'h01)) else $error("oe");
	AST_PORT: assert property (RD_I && ADDR_I == OFF_PORT_F_PINS_PINS
		|=> (RDATA_O & PORT_F_PINS_ANALOG_O) == 8'h00) else $error("analog pin read");
	C_IRQ: cover property (CMP_IRQ_O);
	C_WAKE: cover property (WAKE_O);
	C_REF: cover property (CMP_POS_INTREF_O);
endmodule : dcc_monitor
bind dcc_top dcc_monitor u_mon (.CLK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
	.CMP_MODE_O, .CMP_ON_O, .CMP_POS_INTREF_O, .PORT_F_PINS_OE_O, .PORT_F_PINS_ANALOG_O, .SLEEP_I,
	.CMP_IRQ_O, .WAKE_O);
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcc_pkg::*;
	logic CLK_I = 1'b0;
	logic RST_B_I = 1'b0;
	logic [3:0] ADDR_I = 4'h0;
	logic [7:0] WDATA_I = 8'h00;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [7:0] PORT_F_PINS_IN_I = 8'h00;
	logic SLEEP_I = 1'b0;
	logic [7:0] RDATA_O, LADDER_CTRL_O, PORT_F_PINS_OUT_O, PORT_F_PINS_OE_O, PORT_F_PINS_ANALOG_O;
	logic [2:0] CMP_MODE_O;
	logic CMP_ON_O, CMP_POS_INTREF_O, CMP_IRQ_O, WAKE_O, raw1, raw2;
	logic CMP_ISW_O, CMP_IRQ_HIGH_O;
	logic [7:0] vp1 = 8'h08, vn1 = 8'h04, vp2 = 8'h02, vn2 = 8'h04, e;
	int n_errors = 0;
	int comparisons = 0;
	int ctl, g;
	always #5 CLK_I = ~CLK_I;
	dcc_top uut (.CLK_I, .RST_B_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
		.CMP1_RAW_I(raw1), .CMP2_RAW_I(raw2), .CMP_MODE_O, .CMP_ON_O, .CMP_ISW_O,
		.CMP_POS_INTREF_O, .LADDER_CTRL_O, .PORT_F_PINS_IN_I, .PORT_F_PINS_OUT_O, .PORT_F_PINS_OE_O,
		.PORT_F_PINS_ANALOG_O, .SLEEP_I, .CMP_IRQ_O, .CMP_IRQ_HIGH_O, .WAKE_O);
	dcc_cores model (.on_i(CMP_ON_O), .intref_i(CMP_POS_INTREF_O), .ref_i(LADDER_CTRL_O),
		.vp1_i(vp1), .vn1_i(vn1), .vp2_i(vp2), .vn2_i(vn2), .raw1_o(raw1), .raw2_o(raw2));
	// Expected control readback from the levels
	function automatic logic [7:0] ectl();
		bit on;
		on = ctl[2:0] != 3'h7;
		return {(on && vp2 > vn2) ^ ctl[5], (on && vp1 > vn1) ^ ctl[4], 6'(ctl)};
	endfunction : ectl
	task chk(input string n, input logic [7:0] s, input logic [7:0] x);
		comparisons++;
		if (s !== x)
		begin
			n_errors++;
			$display("unexpected %s exp %h seen %h", n, x, s);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1;
		chk("rdata", RDATA_O, x);
	endtask : rd
	task wt(input int n);
		repeat (n) @(posedge CLK_I);
		#1;
	endtask : wt
	task end_of_test;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test
	initial
	begin
		#100us;
		n_errors++;
		end_of_test;
	end
	initial
	begin
		g = $urandom(25241);
		repeat (12) @(posedge CLK_I);
		RST_B_I <= 1'b1;
		PORT_F_PINS_IN_I <= g[7:0];
		ctl = 8'h07;
		rd(OFF_CMP_CTRL, 8'h07);
		rd(OFF_PORT_F_PINS_PINS, PORT_F_PINS_IN_I & PORT_F_PINS_MASK & ~ANALOG_PINS);
		rd(4'hF, 8'h00);
		wr(OFF_PORT_F_PINS_DIR, 8'h5A);
		wt(1);
		chk("oe", PORT_F_PINS_OE_O, ~8'h5A & PORT_F_PINS_MASK);
		chk("analog", PORT_F_PINS_ANALOG_O, ANALOG_PINS);
		wr(OFF_CONV_CTRL1, 8'h0F);
		wt(1);
		chk("digital", PORT_F_PINS_ANALOG_O, 8'h00);
		rd(OFF_PORT_F_PINS_PINS, PORT_F_PINS_IN_I & PORT_F_PINS_MASK);
		$display("test reset done");
		ctl = 8'h03;
		wr(OFF_CMP_CTRL, 8'hC3);
		wt(4);
		rd(OFF_CMP_CTRL, ectl());
		ctl = 8'h33;
		wr(OFF_CMP_CTRL, 8'h33);
		wt(4);
		e = ectl();
		rd(OFF_CMP_CTRL, e);
		chk("pins", {6'h00, PORT_F_PINS_OUT_O[2:1]}, {6'h00, e[7:6]});
		$display("test results done");
		wr(OFF_FLAGS2, 8'h00);
		rd(OFF_FLAGS2, 8'h00);
		vp1 <= 8'h01;
		wt(4);
		rd(OFF_FLAGS2, 8'h40);
		wr(OFF_FLAGS2, 8'h00);
		rd(OFF_FLAGS2, 8'h40);
		rd(OFF_CMP_CTRL, ectl());
		wr(OFF_FLAGS2, 8'h00);
		rd(OFF_FLAGS2, 8'h00);
		wr(OFF_FLAGS2, 8'h40);
		rd(OFF_FLAGS2, 8'h40);
		$display("test flag done");
		for (int i = 0; i < 6; i++)
		begin
			g = (i == 5) ? 7 : $urandom;
			wr(OFF_INT_CTRL, {g[1:0], 6'h00});
			wr(OFF_ENABLES2, {1'b0, g[2], 6'h00});
			wt(2);
			chk("irq", {7'h00, CMP_IRQ_O}, {7'h00, &g[2:0]});
		end
		wr(OFF_PRIO2, 8'h40);
		wt(2);
		chk("irq_high", {7'h00, CMP_IRQ_HIGH_O}, 8'h01);
		@(posedge CLK_I);
		SLEEP_I <= 1'b1;
		rd(OFF_CMP_CTRL, ectl());
		wr(OFF_FLAGS2, 8'h00);
		vp2 <= 8'h09;
		wt(4);
		chk("wake", {7'h00, WAKE_O}, 8'h01);
		@(posedge CLK_I);
		SLEEP_I <= 1'b0;
		rd(OFF_CMP_CTRL, ectl());
		$display("test sleep done");
		wr(OFF_CMP_CTRL, 8'h0E);
		wt(1);
		chk("intref", {7'h00, CMP_POS_INTREF_O}, 8'h01);
		chk("isw", {7'h00, CMP_ISW_O}, 8'h01);
		wr(OFF_LADDER, 8'h0F);
		wt(4);
		rd(OFF_CMP_CTRL, 8'hCE);
		wr(OFF_CMP_CTRL, 8'h07);
		wt(1);
		chk("off", {7'h00, CMP_ON_O}, 8'h00);
		$display("test intref done");
		end_of_test;
	end
endmodule : tb
`default_nettype wire
